// File: pio_pkg.sv
package pio_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_IRQ_ONE = 8'h08;
  localparam logic [7:0] OFS_IRQ_TWO = 8'h0C;
  localparam logic [7:0] OFS_STRAP = 8'h10;

  // reset values
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [17:0] DIR_RST = 18'h0_0000;
  localparam logic [31:0] IRQ_RST = 32'h0000_0000;

  // port geometry
  localparam int PORT_W = 32;
  localparam int LO_W = 16;
  localparam int DIR_W = 18;
  localparam int DIR_HI_BYTE = 16;
  localparam int DIR_LO_BYTE = 17;

  // interrupt slot layout, four 8-bit slots per config register
  localparam int SLOTS = 8;
  localparam int SLOT_W = 8;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 5;
  localparam int POL_BIT = 5;
  localparam int TRIG_BIT = 6;
  localparam int EN_BIT = 7;

  // shared pin positions
  localparam int PIN_TX_ONE = 15;
  localparam int PIN_RX_ONE = 14;
  localparam int PIN_RTS_ONE = 13;
  localparam int PIN_CTS_ONE = 12;
  localparam int PIN_TX_TWO = 11;
  localparam int PIN_RX_TWO = 10;
  localparam int PIN_RTS_TWO = 9;
  localparam int PIN_CTS_TWO = 8;
  localparam int PIN_UART_CLK = 3;
  localparam int PIN_BOOT_EDAC = 2;
  localparam int PIN_BOOT_WIDTH = 0;

  // strap sampling waits for the input filter to settle
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: pio_port.sv
// Overview of operation
// R01 - 32-bit port, low 16 per-bit direction
// R02 - upper 16 on data bus, 8-bit mode only
// R03 - upper half direction per byte, bits 16/17
// R04 - data read returns live pin levels
// R05 - written value driven only on output pins
// R06 - direction bit 0 input, 1 output
// R07 - eight interrupts, levels 4,5,6,7,10,12,13,15
// R08 - per-slot select of source bit 0..31
// R09 - polarity: high/rising or low/falling
// R10 - trigger type: edge when set, else level
// R11 - enable bit masks each interrupt
// R12 - uart outputs take pins 15,13,11,9
// R13 - boot straps pins 2..0, pin 3 uart clock
// R14 - direction bits 31..18 ignore writes
// R15 - four slots per config register
// R16 - inputs synchronised, edges give one-cycle pulse
// R17 - pin 3 feeds uart scaler, below half clock
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
module pio_port (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // dedicated port pins
  input wire logic [15:0] general_port_pins_in,
  output logic [15:0] general_port_pins_out,
  output logic [15:0] general_port_pins_oe,
  // low half of memory data bus
  input wire logic [15:0] bus_d_in,
  output logic [15:0] bus_d_out,
  output logic [15:0] bus_d_oe,
  input wire logic mem_all_8bit,
  // uart sharing
  input wire logic [1:0] uart_tx,
  input wire logic [1:0] uart_rts,
  input wire logic [1:0] uart_tx_en,
  input wire logic [1:0] uart_flow_en,
  output logic [1:0] uart_rx,
  output logic [1:0] uart_cts,
  output logic uart_ext_clk,
  // boot straps
  output logic [1:0] boot_prom_width,
  output logic boot_prom_edac,
  // port interrupts, slot 0..7 = levels 4,5,6,7,10,12,13,15
  output logic [7:0] port_irq
);

  logic [31:0] data_out;
  logic [17:0] port_direction_bits;
  logic [31:0] port_irq_config_one;
  logic [31:0] port_irq_config_two;
  logic [31:0] sync1, sync2, sync3, pin_val, pin_prev;
  logic [2:0] settle_cnt;
  logic [31:0] dir_merged;
  logic strap_done;
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] rd_word;
  logic rd_hit, wr_hit;
  logic [15:0] next_lo_out, next_lo_oe, next_hi_oe;
  logic [7:0] next_irq;
  logic [63:0] cfg_all;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // three-flop synchroniser, value accepted when stages two and three agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 32'h0000_0000;
      sync2 <= 32'h0000_0000;
      sync3 <= 32'h0000_0000;
      pin_val <= 32'h0000_0000;
      pin_prev <= 32'h0000_0000;
    end else if (clk_en) begin
      sync1 <= {bus_d_in, general_port_pins_in}; // R16
      sync2 <= sync1;
      sync3 <= sync2;
      pin_val <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & pin_val);
      pin_prev <= pin_val;
    end
  end

  // axi write address/data, taken in either order
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pio_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign dir_merged = merge({14'h0000, port_direction_bits}, w_data, w_strb);

  always_comb begin
    unique case ({aw_addr[7:2], 2'b00})
      pio_pkg::OFS_DATA, pio_pkg::OFS_DIR, pio_pkg::OFS_IRQ_ONE,
      pio_pkg::OFS_IRQ_TWO, pio_pkg::OFS_STRAP: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // register writes; strap register is read-only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= pio_pkg::DATA_RST;
      port_direction_bits <= pio_pkg::DIR_RST;
      port_irq_config_one <= pio_pkg::IRQ_RST;
      port_irq_config_two <= pio_pkg::IRQ_RST;
    end else if (clk_en && do_write) begin
      unique case ({aw_addr[7:2], 2'b00})
        pio_pkg::OFS_DATA: data_out <= merge(data_out, w_data, w_strb);
        pio_pkg::OFS_DIR: port_direction_bits <= dir_merged[17:0]; // R14
        pio_pkg::OFS_IRQ_ONE: port_irq_config_one <=
          merge(port_irq_config_one, w_data, w_strb); // R15
        pio_pkg::OFS_IRQ_TWO: port_irq_config_two <=
          merge(port_irq_config_two, w_data, w_strb); // R15
        default: ;
      endcase
    end
  end

  // read decode
  always_comb begin
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      pio_pkg::OFS_DATA: rd_word = pin_val; // R04
      pio_pkg::OFS_DIR: rd_word = {14'h0000, port_direction_bits}; // R14
      pio_pkg::OFS_IRQ_ONE: rd_word = port_irq_config_one;
      pio_pkg::OFS_IRQ_TWO: rd_word = port_irq_config_two;
      pio_pkg::OFS_STRAP: rd_word = {29'h0000_0000, boot_prom_edac,
                                     boot_prom_width};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pio_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? pio_pkg::RESP_OKAY : pio_pkg::RESP_SLVERR;
      end else begin
        if (!s_axi_rvalid) begin
          s_axi_arready <= 1'b1;
        end
        if (s_axi_rvalid && s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end
    end
  end

  // pin drive, uart functions override the port register
  always_comb begin
    next_lo_out = data_out[15:0]; // R05
    next_lo_oe = port_direction_bits[15:0]; // R01 R06
    if (uart_tx_en[0]) begin
      next_lo_out[pio_pkg::PIN_TX_ONE] = uart_tx[0]; // R12
      next_lo_oe[pio_pkg::PIN_TX_ONE] = 1'b1;
    end
    if (uart_flow_en[0]) begin
      next_lo_out[pio_pkg::PIN_RTS_ONE] = uart_rts[0]; // R12
      next_lo_oe[pio_pkg::PIN_RTS_ONE] = 1'b1;
    end
    if (uart_tx_en[1]) begin
      next_lo_out[pio_pkg::PIN_TX_TWO] = uart_tx[1]; // R12
      next_lo_oe[pio_pkg::PIN_TX_TWO] = 1'b1;
    end
    if (uart_flow_en[1]) begin
      next_lo_out[pio_pkg::PIN_RTS_TWO] = uart_rts[1]; // R12
      next_lo_oe[pio_pkg::PIN_RTS_TWO] = 1'b1;
    end
    // bus lanes belong to the memory controller unless all areas are 8-bit
    next_hi_oe = {{8{port_direction_bits[pio_pkg::DIR_HI_BYTE]}},
                  {8{port_direction_bits[pio_pkg::DIR_LO_BYTE]}}}
                 & {16{mem_all_8bit}}; // R02 R03
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      general_port_pins_out <= 16'h0000;
      general_port_pins_oe <= 16'h0000;
      bus_d_out <= 16'h0000;
      bus_d_oe <= 16'h0000;
    end else if (clk_en) begin
      general_port_pins_out <= next_lo_out;
      general_port_pins_oe <= next_lo_oe;
      bus_d_out <= data_out[31:16]; // R05
      bus_d_oe <= next_hi_oe;
    end
  end

  // uart inputs and alternative scaler clock; pin 3 must stay under
  // half the system clock or the filter drops edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      uart_rx <= 2'h3;
      uart_cts <= 2'h0;
      uart_ext_clk <= 1'b0;
    end else if (clk_en) begin
      uart_rx <= {pin_val[pio_pkg::PIN_RX_TWO],
                  pin_val[pio_pkg::PIN_RX_ONE]}; // R12
      uart_cts <= {pin_val[pio_pkg::PIN_CTS_TWO],
                   pin_val[pio_pkg::PIN_CTS_ONE]}; // R12
      uart_ext_clk <= pin_val[pio_pkg::PIN_UART_CLK]; // R13 R17
    end
  end

  // straps caught once, after the filter has seen settled levels
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt <= 3'h0;
      strap_done <= 1'b0;
      boot_prom_width <= 2'h0;
      boot_prom_edac <= 1'b0;
    end else if (clk_en && !strap_done) begin
      if (settle_cnt == pio_pkg::STRAP_SETTLE) begin
        strap_done <= 1'b1;
        boot_prom_width <= pin_val[pio_pkg::PIN_BOOT_WIDTH +: 2]; // R13
        boot_prom_edac <= pin_val[pio_pkg::PIN_BOOT_EDAC]; // R13
      end else begin
        settle_cnt <= settle_cnt + 3'h1;
      end
    end
  end

  assign cfg_all = {port_irq_config_two, port_irq_config_one};

  for (genvar k = 0; k < pio_pkg::SLOTS; k++) begin : g_slot
    logic [7:0] cfg;
    logic src, prev, edge_hit, level_hit;
    assign cfg = cfg_all[k*pio_pkg::SLOT_W +: pio_pkg::SLOT_W]; // R15
    assign src = pin_val[cfg[pio_pkg::SEL_LSB +: pio_pkg::SEL_W]]; // R08
    assign prev = pin_prev[cfg[pio_pkg::SEL_LSB +: pio_pkg::SEL_W]];
    assign edge_hit = cfg[pio_pkg::POL_BIT] ? (src & ~prev)
                                            : (~src & prev); // R09 R16
    assign level_hit = cfg[pio_pkg::POL_BIT] ? src : ~src; // R09
    assign next_irq[k] = cfg[pio_pkg::EN_BIT] &
      (cfg[pio_pkg::TRIG_BIT] ? edge_hit : level_hit); // R10 R11
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_irq <= 8'h00;
    end else if (clk_en) begin
      port_irq <= next_irq; // R07
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence pin0_high_steady;
    (clk_en && general_port_pins_in[0])[*4];
  endsequence

  lo_dir_a: assert property (clk_en |=> general_port_pins_oe[7:0] == $past(port_direction_bits[7:0])) else $error("low pin enable not from direction"); // R06
  lo_value_a: assert property (clk_en |=> general_port_pins_out[7:0] == $past(data_out[7:0])) else $error("low pin value not from data"); // R05
  hi_gate_a: assert property (clk_en && !mem_all_8bit |=> bus_d_oe == 16'h0000) else $error("bus lanes driven outside 8-bit mode"); // R02
  byte_dir_a: assert property (clk_en && mem_all_8bit |=> bus_d_oe[15:8] == {8{$past(port_direction_bits[16])}} && bus_d_oe[7:0] == {8{$past(port_direction_bits[17])}}) else $error("bus byte direction wrong"); // R03
  uart_share_a: assert property (clk_en && uart_tx_en[0] |=> general_port_pins_oe[15] && general_port_pins_out[15] == $past(uart_tx[0])) else $error("uart tx not on pin 15"); // R12
  sync_filter_a: assert property (pin0_high_steady |=> pin_val[0]) else $error("steady input not accepted"); // R16
  edge_pulse_a: assert property (clk_en && $stable(port_irq_config_two) && port_irq_config_two[6] && port_irq[4] |=> !port_irq[4]) else $error("edge interrupt longer than one cycle"); // R16
  mask_irq_a: assert property (clk_en && !port_irq_config_one[7] |=> !port_irq[0]) else $error("masked interrupt forwarded"); // R11
  level_irq_a: assert property (clk_en && !port_irq_config_one[6] && port_irq_config_one[7] && pin_val[port_irq_config_one[4:0]] == port_irq_config_one[5] |=> port_irq[0]) else $error("level interrupt missed"); // R09
  read_live_a: assert property (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == pio_pkg::OFS_DATA |=> s_axi_rdata == $past(pin_val)) else $error("data read not live pins"); // R04
  dir_upper_a: assert property (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == pio_pkg::OFS_DIR |=> s_axi_rdata[31:18] == 14'h0000) else $error("direction upper bits not zero"); // R14

endmodule

// File: pio_pin_model.sv
module pio_pin_model (
  // device drive
  input wire logic [15:0] lo_out,
  input wire logic [15:0] lo_oe,
  input wire logic [15:0] hi_out,
  input wire logic [15:0] hi_oe,
  // levels from the external devices
  input wire logic [15:0] lo_ext,
  input wire logic [15:0] hi_ext,
  // resolved pins
  output logic [15:0] lo_pins,
  output logic [15:0] hi_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin shows the external device, never a stale drive value
  assign lo_pins = (lo_out & lo_oe) | (lo_ext & ~lo_oe);
  assign hi_pins = (hi_out & hi_oe) | (hi_ext & ~hi_oe);
endmodule

// File: parallel_io_port_irq_bench.sv
module parallel_io_port_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] lo_ext = 16'h0006, hi_ext = 16'h0000, lo_pins, hi_pins;
  logic [15:0] general_port_pins_out, general_port_pins_oe;
  logic [15:0] bus_d_out, bus_d_oe;
  logic mem_all_8bit = 1'h0, uart_ext_clk, boot_prom_edac;
  logic [1:0] uart_tx = 2'h3, uart_rts = 2'h3;
  logic [1:0] uart_tx_en = 2'h0, uart_flow_en = 2'h0;
  logic [1:0] uart_rx, uart_cts, boot_prom_width;
  logic [7:0] port_irq;
  int fail_count = 0;
  int comparisons = 0;
  int cnt4 = 0;
  int cnt5 = 0;

  always #4 core_clk = ~core_clk;

  pio_port dut (.core_clk, .arst_n, .clk_en(1'h1), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .general_port_pins_in(lo_pins), .general_port_pins_out,
    .general_port_pins_oe, .bus_d_in(hi_pins), .bus_d_out, .bus_d_oe,
    .mem_all_8bit, .uart_tx, .uart_rts, .uart_tx_en, .uart_flow_en,
    .uart_rx, .uart_cts, .uart_ext_clk, .boot_prom_width,
    .boot_prom_edac, .port_irq);

  pio_pin_model pins (.lo_out(general_port_pins_out),
    .lo_oe(general_port_pins_oe), .hi_out(bus_d_out), .hi_oe(bus_d_oe),
    .lo_ext, .hi_ext, .lo_pins, .hi_pins);

  // edge slots must pulse exactly once per transition
  always @(posedge core_clk) begin
    if (port_irq[4] === 1'h1) cnt4 <= cnt4 + 1;
    if (port_irq[5] === 1'h1) cnt5 <= cnt5 + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    logic ad;
    logic wd;
    n = 0;
    ad = 1'h0;
    wd = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(ad && wd) && n < 99) begin
      @(posedge core_clk);
      n++;
      if (!ad && s_axi_awready === 1'h1) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wd && s_axi_wready === 1'h1) begin
        wd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_bvalid !== 1'h1 && n < 99);
    if (n >= 99) begin
      fail_count++;
      $display("[FAIL] %0t write timed out", $time);
    end
    chk(32'(s_axi_bresp), 32'(er), "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_arready !== 1'h1 && n < 99);
    s_axi_arvalid <= 1'h0;
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_rvalid !== 1'h1 && n < 99);
    if (n >= 99) begin
      fail_count++;
      $display("[FAIL] %0t read timed out", $time);
    end
    chk(s_axi_rdata, ed, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    stop_test;
  end

  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'h1;
    repeat (8) @(posedge core_clk);
    rd(pio_pkg::OFS_DIR, 32'h0000_0000, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_IRQ_ONE, 32'h0000_0000, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_IRQ_TWO, 32'h0000_0000, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_DATA, 32'h0000_0006, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_STRAP, 32'h0000_0006, pio_pkg::RESP_OKAY);
    wr(8'h14, 32'hFFFF_FFFF, pio_pkg::RESP_SLVERR);
    rd(8'h14, 32'h0000_0000, pio_pkg::RESP_SLVERR);
    $display("reset and map test done");
    lo_ext <= 16'h5A5A;
    hi_ext <= 16'h0F0F;
    wr(pio_pkg::OFS_DIR, 32'hFFFF_00F0, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_DIR, 32'h0003_00F0, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_DATA, 32'h1234_ABCD, pio_pkg::RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(32'(general_port_pins_oe), 32'h0000_00F0, "oe");
    chk(32'(general_port_pins_out & general_port_pins_oe), 32'h0000_00C0,
        "out");
    chk(32'(bus_d_oe), 32'h0000_0000, "bus oe 16 bit mode");
    mem_all_8bit <= 1'h1;
    repeat (8) @(posedge core_clk);
    chk(32'(bus_d_oe), 32'h0000_FFFF, "bus oe");
    chk(32'(bus_d_out), 32'h0000_1234, "bus out");
    rd(pio_pkg::OFS_DATA, 32'h1234_5ACA, pio_pkg::RESP_OKAY);
    wr(pio_pkg::OFS_DIR, 32'h0001_0000, pio_pkg::RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(32'(bus_d_oe), 32'h0000_FF00, "upper byte lane");
    wr(pio_pkg::OFS_DIR, 32'h0002_0000, pio_pkg::RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(32'(bus_d_oe), 32'h0000_00FF, "lower byte lane");
    $display("direction and data test done");
    lo_ext <= 16'h0000;
    hi_ext <= 16'h8000;
    wr(pio_pkg::OFS_DIR, 32'h0000_0000, pio_pkg::RESP_OKAY);
    // slot0 high level pin5, slot1 low level pin6, slot2 masked, slot3 pin31
    wr(pio_pkg::OFS_IRQ_ONE, 32'hBF25_86A5, pio_pkg::RESP_OKAY);
    rd(pio_pkg::OFS_IRQ_ONE, 32'hBF25_86A5, pio_pkg::RESP_OKAY);
    // slot4 rising edge, slot5 falling edge, both on port bit 20
    wr(pio_pkg::OFS_IRQ_TWO, 32'h0000_D4F4, pio_pkg::RESP_OKAY);
    repeat (8) @(posedge core_clk);
    chk(32'(port_irq), 32'h0000_000A, "irq low");
    lo_ext <= 16'h0060;
    repeat (8) @(posedge core_clk);
    chk(32'(port_irq), 32'h0000_0009, "irq high");
    hi_ext <= 16'h8010;
    repeat (10) @(posedge core_clk);
    chk(32'(cnt4), 32'h0000_0001, "rise pulse");
    chk(32'(cnt5), 32'h0000_0000, "no fall pulse");
    hi_ext <= 16'h8000;
    repeat (10) @(posedge core_clk);
    chk(32'(cnt4), 32'h0000_0001, "no rise pulse");
    chk(32'(cnt5), 32'h0000_0001, "fall pulse");
    s_axi_wstrb <= 4'h4;
    wr(pio_pkg::OFS_IRQ_TWO, 32'hFFFF_FFFF, pio_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(pio_pkg::OFS_IRQ_TWO, 32'h00FF_D4F4, pio_pkg::RESP_OKAY);
    chk(32'(port_irq), 32'h0000_0009, "enable makes no edge");
    $display("interrupt test done");
    uart_tx_en <= 2'h1;
    uart_flow_en <= 2'h2;
    uart_tx <= 2'h0;
    lo_ext <= 16'h4109;
    repeat (8) @(posedge core_clk);
    chk(32'(general_port_pins_oe), 32'h0000_8200, "uart oe");
    chk(32'(general_port_pins_out & general_port_pins_oe), 32'h0000_0200,
        "uart out");
    chk(32'(uart_rx), 32'h0000_0001, "uart rx");
    chk(32'(uart_cts), 32'h0000_0002, "uart cts");
    chk(32'(uart_ext_clk), 32'h0000_0001, "uart clock pin");
    chk(32'(boot_prom_width), 32'h0000_0002, "strap width");
    chk(32'(boot_prom_edac), 32'h0000_0001, "strap edac");
    $display("uart and strap test done");
    stop_test;
  end
endmodule
